// *** rtl/mct_pkg.sv ***
package mct_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_CH2_CONTROL = 8'h04;
    localparam logic [7:0] OFF_CH2_IO_CONTROL = 8'h08;
    localparam logic [7:0] OFF_CH2_IRQ_ENABLE = 8'h0C;
    localparam logic [7:0] OFF_FLAGS = 8'h10;
    localparam logic [7:0] OFF_OUTPUT_ENABLE_CTRL = 8'h14;
    localparam logic [7:0] OFF_OUTPUT_POLARITY_CTRL = 8'h18;
    localparam logic [7:0] OFF_QUAD_COUNTER = 8'h20;
    localparam logic [7:0] OFF_CH2_GRA = 8'h24;
    localparam logic [7:0] OFF_CH2_GRB = 8'h28;
    localparam logic [7:0] OFF_PWM_COUNTER_LEAD = 8'h30;
    localparam logic [7:0] OFF_PWM_COUNTER_LAG = 8'h34;
    // Four general registers of channels 3/4 at consecutive words, then four shadows
    localparam logic [7:0] OFF_GR_BASE = 8'h38;
    localparam logic [7:0] OFF_BR_BASE = 8'h48;

    // Mode register fields
    localparam int MODE_QUAD_EN = 0;
    localparam int MODE_RUN2 = 1;
    localparam int MODE_RUN34 = 2;
    localparam int MODE_PWM_LO = 3;
    localparam int MODE_BUF_LO = 5;
    localparam int MODE_CAP3A = 9;
    localparam logic [1:0] PWM_NORMAL = 2'h0;
    localparam logic [1:0] PWM_RSYNC = 2'h2;
    localparam logic [1:0] PWM_COMPL = 2'h3;

    // Counter clear select codes
    localparam logic [1:0] CLR_NONE = 2'h0;
    localparam logic [1:0] CLR_BY_A = 2'h1;
    localparam logic [1:0] CLR_BY_B = 2'h2;

    // Flag positions: {wrap, b, a} for channels 2, 3, 4
    localparam int FLG_CH2 = 0;
    localparam int FLG_CH3 = 3;
    localparam int FLG_CH4 = 6;

    // Polarity register fields
    localparam int POL_LS3 = 0;
    localparam int POL_LS4 = 1;
    localparam int POL_EXT_TRIGGER_DISABLE = 4;

    // Reset values
    localparam logic [9:0] MODE_RST = 10'h000;
    localparam logic [5:0] OE_RST = 6'h00;
    localparam logic [1:0] LS_RST = 2'h0;
    localparam logic EXT_TRIGGER_DISABLE_RST = 1'b1;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] GR_RST = 16'hFFFF;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** rtl/mct_timer.sv ***
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module mct_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic phase_input_a,
    input wire logic phase_input_b,
    input wire logic capture_compare_pin_a,
    input wire logic capture_compare_pin_b,
    input wire logic ch3_capture_pin,
    input wire logic ch1_capture_a,
    input wire logic [5:0] port_value,
    input wire logic [5:0] port_dir,
    output logic [5:0] pwm_pin_out,
    output logic [5:0] pwm_pin_oe
);
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] strb);
        merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic is_gr(input logic [7:0] a, input logic [7:0] base);
        is_gr = (a >= base) && (a < base + 8'h10) && (a[1:0] == 2'h0);
    endfunction

    // Bus state
    logic [7:0] aw_addr;
    logic aw_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_full;
    logic wr_go;
    logic rd_go;
    logic [7:0] wa;
    logic [31:0] rd_mux;
    logic rd_ok;
    logic wr_ok;

    // Control and status
    logic [9:0] mode_reg;
    logic [1:0] ch2_control;
    logic [1:0] ch2_io_control;
    logic [2:0] ch2_irq_enable;
    logic [5:0] output_enable_ctrl;
    logic [1:0] level_sel;
    logic ext_trigger_disable;
    logic [8:0] flags;
    logic [8:0] seen;
    logic [8:0] flag_set;
    logic [8:0] flag_clr;

    // Counters and compare/capture registers
    logic [15:0] quad_counter;
    logic [15:0] ch2_gra;
    logic [15:0] ch2_grb;
    logic [15:0] pwm_counter_lead;
    logic [15:0] pwm_counter_lag;
    logic [15:0] gr [4];
    logic [15:0] br [4];
    logic count_down;
    logic qa_q, qb_q, cpa_q, cpb_q, cp3_q;
    logic [2:0] rs_lvl;

    // Derived strobes
    logic [1:0] pmode;
    logic pwm_on, compl, rsync;
    logic ea, eb, q_up, tick2, up2, cap2a, cap2b, m2a, m2b, clr2, wrap2;
    logic run34, m_per, turn_down, uflow, cap3, wrap3, wrap4, lag_neg;
    logic [3:0] m, xfer;
    logic [3:0] wr_gr, wr_br;
    logic [5:0] pin_val;

    assign wa = aw_addr;
    assign wr_go = aw_full && w_full && !s_axi_bvalid;
    assign rd_go = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= mct_pkg::RESP_OKAY;
        end
        else
        begin
            // Address and data are latched independently, in either order
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr <= s_axi_awaddr;
                aw_full <= 1'b1;
            end
            else if (wr_go)
                aw_full <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_full <= 1'b1;
            end
            else if (wr_go)
                w_full <= 1'b0;
            s_axi_awready <= !aw_full && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_full && !(s_axi_wvalid && s_axi_wready);
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? mct_pkg::RESP_OKAY : mct_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_comb
    begin
        wr_ok = 1'b1;
        unique case (wa)
            mct_pkg::OFF_MODE, mct_pkg::OFF_CH2_CONTROL, mct_pkg::OFF_CH2_IO_CONTROL,
            mct_pkg::OFF_CH2_IRQ_ENABLE, mct_pkg::OFF_FLAGS, mct_pkg::OFF_OUTPUT_ENABLE_CTRL,
            mct_pkg::OFF_OUTPUT_POLARITY_CTRL, mct_pkg::OFF_QUAD_COUNTER, mct_pkg::OFF_CH2_GRA,
            mct_pkg::OFF_CH2_GRB, mct_pkg::OFF_PWM_COUNTER_LEAD, mct_pkg::OFF_PWM_COUNTER_LAG:
                wr_ok = 1'b1;
            default:
                wr_ok = is_gr(wa, mct_pkg::OFF_GR_BASE) || is_gr(wa, mct_pkg::OFF_BR_BASE);
        endcase
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            mct_pkg::OFF_MODE: rd_mux[9:0] = mode_reg;
            mct_pkg::OFF_CH2_CONTROL: rd_mux[1:0] = ch2_control;
            mct_pkg::OFF_CH2_IO_CONTROL: rd_mux[1:0] = ch2_io_control;
            mct_pkg::OFF_CH2_IRQ_ENABLE: rd_mux[2:0] = ch2_irq_enable;
            mct_pkg::OFF_FLAGS: rd_mux[8:0] = flags;
            mct_pkg::OFF_OUTPUT_ENABLE_CTRL: rd_mux[5:0] = output_enable_ctrl;
            mct_pkg::OFF_OUTPUT_POLARITY_CTRL:
                rd_mux[4:0] = {ext_trigger_disable, 2'h0, level_sel};
            mct_pkg::OFF_QUAD_COUNTER: rd_mux[15:0] = quad_counter;
            mct_pkg::OFF_CH2_GRA: rd_mux[15:0] = ch2_gra;
            mct_pkg::OFF_CH2_GRB: rd_mux[15:0] = ch2_grb;
            mct_pkg::OFF_PWM_COUNTER_LEAD: rd_mux[15:0] = pwm_counter_lead;
            mct_pkg::OFF_PWM_COUNTER_LAG: rd_mux[15:0] = pwm_counter_lag;
            default:
            begin
                if (is_gr(s_axi_araddr, mct_pkg::OFF_GR_BASE))
                    rd_mux[15:0] = gr[s_axi_araddr[3:2] - 2'h2];
                else if (is_gr(s_axi_araddr, mct_pkg::OFF_BR_BASE))
                    rd_mux[15:0] = br[s_axi_araddr[3:2] - 2'h2];
                else
                    rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= mct_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !rd_go;
            if (rd_go)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_ok ? mct_pkg::RESP_OKAY : mct_pkg::RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Write strobes for the channel 3/4 register arrays
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            wr_gr[i] = wr_go && (wa == mct_pkg::OFF_GR_BASE + 8'(4 * i));
            wr_br[i] = wr_go && (wa == mct_pkg::OFF_BR_BASE + 8'(4 * i));
        end
    end

    // Channel 2: phase counting replaces the internal clock when enabled
    assign ea = phase_input_a != qa_q;
    assign eb = phase_input_b != qb_q;
    assign q_up = (eb && phase_input_b && !phase_input_a)
        || (ea && phase_input_a && phase_input_b)
        || (eb && !phase_input_b && phase_input_a)
        || (ea && !phase_input_a && !phase_input_b);
    assign tick2 = mode_reg[mct_pkg::MODE_RUN2]
        && (!mode_reg[mct_pkg::MODE_QUAD_EN] || ea || eb);
    assign up2 = !mode_reg[mct_pkg::MODE_QUAD_EN] || q_up;
    assign cap2a = ch2_io_control[0] && capture_compare_pin_a && !cpa_q;
    assign cap2b = ch2_io_control[1] && capture_compare_pin_b && !cpb_q;
    assign m2a = tick2 && !ch2_io_control[0] && (quad_counter == ch2_gra);
    assign m2b = tick2 && !ch2_io_control[1] && (quad_counter == ch2_grb);
    assign clr2 = (ch2_control == mct_pkg::CLR_BY_A && (m2a || cap2a))
        || (ch2_control == mct_pkg::CLR_BY_B && (m2b || cap2b));
    assign wrap2 = tick2 && !clr2 && (up2 ? quad_counter == mct_pkg::CNT_MAX
        : quad_counter == mct_pkg::CNT_RST);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            qa_q <= 1'b0;
            qb_q <= 1'b0;
            cpa_q <= 1'b0;
            cpb_q <= 1'b0;
            cp3_q <= 1'b0;
        end
        else
        begin
            qa_q <= phase_input_a;
            qb_q <= phase_input_b;
            cpa_q <= capture_compare_pin_a;
            cpb_q <= capture_compare_pin_b;
            cp3_q <= ch3_capture_pin;
        end
    end

    // Clear beats a software write, a write beats a count step
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            quad_counter <= mct_pkg::CNT_RST;
        else if (clr2)
            quad_counter <= mct_pkg::CNT_RST;
        else if (wr_go && wa == mct_pkg::OFF_QUAD_COUNTER)
            quad_counter <= merge16(quad_counter, w_data, w_strb);
        else if (tick2)
            quad_counter <= up2 ? quad_counter + 16'h0001 : quad_counter - 16'h0001;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ch2_gra <= mct_pkg::GR_RST;
            ch2_grb <= mct_pkg::GR_RST;
        end
        else
        begin
            if (cap2a)
                ch2_gra <= quad_counter;
            else if (wr_go && wa == mct_pkg::OFF_CH2_GRA)
                ch2_gra <= merge16(ch2_gra, w_data, w_strb);
            if (cap2b)
                ch2_grb <= quad_counter;
            else if (wr_go && wa == mct_pkg::OFF_CH2_GRB)
                ch2_grb <= merge16(ch2_grb, w_data, w_strb);
        end
    end

    // Channels 3/4
    assign pmode = mode_reg[mct_pkg::MODE_PWM_LO +: 2];
    assign compl = pmode == mct_pkg::PWM_COMPL;
    assign rsync = pmode == mct_pkg::PWM_RSYNC;
    assign pwm_on = compl || rsync;
    assign run34 = mode_reg[mct_pkg::MODE_RUN34];
    assign cap3 = !pwm_on && mode_reg[mct_pkg::MODE_CAP3A] && ch3_capture_pin && !cp3_q;
    assign m_per = run34 && (pwm_on || !mode_reg[mct_pkg::MODE_CAP3A])
        && (pwm_counter_lead == gr[0]);
    assign turn_down = compl && m_per && !count_down;
    assign uflow = run34 && compl && count_down && pwm_counter_lag == mct_pkg::CNT_RST;
    assign lag_neg = compl && pwm_counter_lag == mct_pkg::CNT_MAX;
    assign wrap3 = run34 && !compl && !(rsync && m_per)
        && pwm_counter_lead == mct_pkg::CNT_MAX;
    assign wrap4 = compl ? uflow
        : (run34 && pwm_counter_lag == mct_pkg::CNT_MAX);

    always_comb
    begin
        m[0] = m_per;
        for (int i = 1; i < 4; i++)
            m[i] = run34 && ((i >= 2 && !pwm_on) ? pwm_counter_lag == gr[i]
                : pwm_counter_lead == gr[i]);
        for (int i = 0; i < 4; i++)
        begin
            unique case (pmode)
                mct_pkg::PWM_COMPL: xfer[i] = turn_down || uflow;
                mct_pkg::PWM_RSYNC: xfer[i] = m_per;
                default: xfer[i] = m[i];
            endcase
            xfer[i] = xfer[i] && mode_reg[mct_pkg::MODE_BUF_LO + i];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pwm_counter_lead <= mct_pkg::CNT_RST;
            pwm_counter_lag <= mct_pkg::CNT_RST;
            count_down <= 1'b0;
        end
        else
        begin
            // Overshoot: the counters take one more up step after the period match
            if (turn_down)
                count_down <= 1'b1;
            else if (uflow || !compl)
                count_down <= 1'b0;
            if (wr_go && wa == mct_pkg::OFF_PWM_COUNTER_LEAD)
                pwm_counter_lead <= merge16(pwm_counter_lead, w_data, w_strb);
            else if (rsync && m_per)
                pwm_counter_lead <= mct_pkg::CNT_RST;
            else if (run34)
                pwm_counter_lead <= (compl && count_down) ? pwm_counter_lead - 16'h0001
                    : pwm_counter_lead + 16'h0001;
            if (wr_go && wa == mct_pkg::OFF_PWM_COUNTER_LAG)
                pwm_counter_lag <= merge16(pwm_counter_lag, w_data, w_strb);
            else if (run34)
                pwm_counter_lag <= (compl && count_down) ? pwm_counter_lag - 16'h0001
                    : pwm_counter_lag + 16'h0001;
        end
    end

    // Transfer loses to a write; capture beats both
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < 4; i++)
            begin
                gr[i] <= mct_pkg::GR_RST;
                br[i] <= mct_pkg::GR_RST;
            end
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (wr_gr[i])
                    gr[i] <= merge16(gr[i], w_data, w_strb);
                else if (xfer[i])
                    gr[i] <= br[i];
                if (wr_br[i])
                    br[i] <= merge16(br[i], w_data, w_strb);
            end
            if (cap3)
            begin
                gr[0] <= pwm_counter_lead;
                if (mode_reg[mct_pkg::MODE_BUF_LO])
                    br[0] <= gr[0];
            end
        end
    end

    // Flags: a hardware set in the clearing cycle wins
    assign flag_set = {wrap4, m[3], m[2], wrap3, m[1], compl ? turn_down : (m[0] || cap3),
        wrap2, m2b || cap2b, m2a || cap2a};
    assign flag_clr = (wr_go && wa == mct_pkg::OFF_FLAGS) ? (seen & ~w_data[8:0]) : 9'h000;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flags <= 9'h000;
            seen <= 9'h000;
        end
        else
        begin
            flags <= (flags & ~flag_clr) | flag_set;
            if (rd_go && s_axi_araddr == mct_pkg::OFF_FLAGS)
                seen <= flags;
            else
                seen <= seen & flags & ~flag_clr;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_reg <= mct_pkg::MODE_RST;
            ch2_control <= mct_pkg::CLR_NONE;
            ch2_io_control <= 2'h0;
            ch2_irq_enable <= 3'h0;
            level_sel <= mct_pkg::LS_RST;
            ext_trigger_disable <= mct_pkg::EXT_TRIGGER_DISABLE_RST;
        end
        else if (wr_go && w_strb[0])
        begin
            unique case (wa)
                mct_pkg::OFF_MODE:
                    mode_reg <= {w_strb[1] ? w_data[9:8] : mode_reg[9:8], w_data[7:0]};
                mct_pkg::OFF_CH2_CONTROL: ch2_control <= w_data[1:0];
                mct_pkg::OFF_CH2_IO_CONTROL: ch2_io_control <= w_data[1:0];
                mct_pkg::OFF_CH2_IRQ_ENABLE: ch2_irq_enable <= w_data[2:0];
                mct_pkg::OFF_OUTPUT_POLARITY_CTRL:
                begin
                    level_sel <= w_data[1:0];
                    ext_trigger_disable <= w_data[mct_pkg::POL_EXT_TRIGGER_DISABLE];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            output_enable_ctrl <= mct_pkg::OE_RST;
        else if (pwm_on && !ext_trigger_disable && ch1_capture_a)
            output_enable_ctrl <= 6'h00;
        else if (wr_go && w_strb[0] && wa == mct_pkg::OFF_OUTPUT_ENABLE_CTRL)
            output_enable_ctrl <= w_data[5:0];
    end

    // Reset-sync levels: low from the period clear, high after own match
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rs_lvl <= 3'h0;
        else
        begin
            for (int k = 0; k < 3; k++)
            begin
                if (m_per)
                    rs_lvl[k] <= 1'b0;
                else if (m[k + 1])
                    rs_lvl[k] <= 1'b1;
            end
        end
    end

    // Complementary: the lag counter drives the positive phase, the lead counter the
    // negative one, so the counter offset is the dead time; values past the period stick
    always_comb
    begin
        logic pos;
        logic neg;
        logic inv;
        pos = 1'b0;
        neg = 1'b0;
        inv = 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            pos = compl ? (!lag_neg && pwm_counter_lag > gr[k + 1]) : rs_lvl[k];
            neg = compl ? (pwm_counter_lead <= gr[k + 1]) : !rs_lvl[k];
            inv = !level_sel[k == 0 ? mct_pkg::POL_LS3 : mct_pkg::POL_LS4];
            pin_val[2 * k] = pos ^ inv;
            pin_val[2 * k + 1] = neg ^ inv;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pwm_pin_out <= 6'h00;
            pwm_pin_oe <= 6'h00;
        end
        else
        begin
            for (int j = 0; j < 6; j++)
            begin
                pwm_pin_out[j] <= (pwm_on && output_enable_ctrl[j]) ? pin_val[j]
                    : port_value[j];
                pwm_pin_oe[j] <= (pwm_on && output_enable_ctrl[j]) || port_dir[j];
            end
        end
    end
endmodule // mct_timer

// *** tb/mct_timer_asserts.sv ***
`timescale 1ns/10ps
module mct_timer_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ch1_capture_a,
    input wire logic [5:0] pwm_pin_oe
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    rst_quiet_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !(|pwm_pin_oe))
        else $error("output active after reset");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    wr_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
    aw_slot_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("address slot not closed");
    rd_one_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read accepted");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    cover property (s_axi_bvalid && s_axi_bresp == mct_pkg::RESP_SLVERR);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (ch1_capture_a ##2 pwm_pin_oe == 6'h00);
endmodule // mct_timer_asserts
bind mct_timer mct_timer_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .ch1_capture_a, .pwm_pin_oe);

// *** tb/mct_quad_src.sv ***
`timescale 1ns/10ps
module mct_quad_src (
    input wire logic aclk,
    input wire logic step,
    input wire logic up,
    output logic phase_a,
    output logic phase_b
);
    // Gray position as {a,b}: 00, 01, 11, 10; a rising index is forward motion
    logic [1:0] pos = 2'h0;
    // Steps arrive six cycles apart, well over the minimum overlap and width
    always_ff @(posedge aclk)
    begin
        if (step)
            pos <= up ? pos + 2'h1 : pos - 2'h1;
    end
    assign phase_a = pos[1];
    assign phase_b = pos[1] ^ pos[0];
endmodule // mct_quad_src

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; $display("FAIL %s exp %h got %h", n, e, g); end end
module tb_top;
    logic aclk = 0;
    logic aresetn = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, g1;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic phase_input_a, phase_input_b, stp = 0, up = 0, ch3_capture_pin = 0, ch1_capture_a = 0;
    logic capture_compare_pin_a = 0, capture_compare_pin_b = 0;
    logic [5:0] port_value = 0, port_dir = 0, pwm_pin_out, pwm_pin_oe;
    int errors = 0, n_tests = 0, cyc = 0, seed = 70013, net = 0;
    always #20 aclk = ~aclk;
    mct_quad_src src (.aclk, .step(stp), .up, .phase_a(phase_input_a), .phase_b(phase_input_b));
    mct_timer uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .phase_input_a, .phase_input_b, .capture_compare_pin_a,
        .capture_compare_pin_b, .ch3_capture_pin, .ch1_capture_a, .port_value, .port_dir,
        .pwm_pin_out, .pwm_pin_oe);
    task conclude;
        if (errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            conclude();
        end
    end
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 0;
            if (s_axi_wready)
                s_axi_wvalid <= 0;
        end
        while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 0;
        end
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    task step(input logic u);
        @(posedge aclk);
        stp <= 1;
        up <= u;
        net = u ? net + 1 : net - 1;
        @(posedge aclk);
        stp <= 0;
        repeat (4) @(posedge aclk);
    endtask
    // Rising edge held two cycles so the capture cannot be missed
    task cap;
        @(posedge aclk);
        ch3_capture_pin <= 1;
        repeat (2) @(posedge aclk);
        ch3_capture_pin <= 0;
        repeat (3) @(posedge aclk);
    endtask
    function automatic logic [15:0] exp_cnt(int n);
        return n[15:0];
    endfunction
    initial
    begin
        repeat (12) @(posedge aclk);
        d = $random(seed);
        port_dir <= d[5:0];
        port_value <= d[13:8];
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        rd(mct_pkg::OFF_MODE);
        `CHK("mode", 32'h0, d)
        rd(mct_pkg::OFF_OUTPUT_POLARITY_CTRL);
        `CHK("polarity", 32'h10, d)
        rd(mct_pkg::OFF_GR_BASE);
        `CHK("pwm_period_compare", {16'h0, mct_pkg::GR_RST}, d)
        rd(8'hFC);
        `CHK("bad rd", {mct_pkg::RESP_SLVERR, 32'h0}, {resp, d})
        wr(8'hFC, 32'h1);
        `CHK("bad wr", mct_pkg::RESP_SLVERR, resp)
        wr(mct_pkg::OFF_MODE, 32'h3);
        repeat (3) step(0);
        rd(mct_pkg::OFF_FLAGS);
        `CHK("flags2", 3'h7, d[2:0])
        wr(mct_pkg::OFF_FLAGS, 32'h0);
        rd(mct_pkg::OFF_FLAGS);
        `CHK("flags2 clr", 3'h0, d[2:0])
        repeat (20)
        begin
            d = $random(seed);
            step(d[0]);
        end
        rd(mct_pkg::OFF_QUAD_COUNTER);
        `CHK("quad", exp_cnt(net), d[15:0])
        wr(mct_pkg::OFF_CH2_IO_CONTROL, 32'h1);
        capture_compare_pin_a <= 1;
        rd(mct_pkg::OFF_CH2_GRA);
        `CHK("cap2", exp_cnt(net), d[15:0])
        wr(mct_pkg::OFF_MODE, 32'h224);
        cap();
        rd(mct_pkg::OFF_FLAGS);
        `CHK("cap flag", 1'b1, d[3])
        rd(mct_pkg::OFF_GR_BASE);
        g1 = d;
        repeat (7) @(posedge aclk);
        cap();
        rd(mct_pkg::OFF_BR_BASE);
        `CHK("shadow", g1, d)
        wr(mct_pkg::OFF_MODE, 32'h14);
        wr(mct_pkg::OFF_OUTPUT_ENABLE_CTRL, 32'h3F);
        wr(mct_pkg::OFF_OUTPUT_POLARITY_CTRL, 32'h0);
        `CHK("oe on", 6'h3F, pwm_pin_oe)
        wr(mct_pkg::OFF_MODE, 32'h10);
        repeat (2) @(posedge aclk);
        d = pwm_pin_out;
        wr(mct_pkg::OFF_OUTPUT_POLARITY_CTRL, 32'h1);
        repeat (2) @(posedge aclk);
        `CHK("invert", ~d[1:0], pwm_pin_out[1:0])
        @(posedge aclk);
        ch1_capture_a <= 1;
        @(posedge aclk);
        ch1_capture_a <= 0;
        repeat (2) @(posedge aclk);
        `CHK("trip oe", port_dir, pwm_pin_oe)
        `CHK("port out", port_value & port_dir, pwm_pin_out & port_dir)
        rd(mct_pkg::OFF_OUTPUT_ENABLE_CTRL);
        `CHK("oe reg", 32'h0, d)
        wr(mct_pkg::OFF_PWM_COUNTER_LAG, 32'h0);
        wr(mct_pkg::OFF_PWM_COUNTER_LEAD, 32'h2);
        wr(mct_pkg::OFF_GR_BASE, 32'h10);
        wr(mct_pkg::OFF_BR_BASE + 8'h04, 32'h8);
        rd(mct_pkg::OFF_FLAGS);
        wr(mct_pkg::OFF_FLAGS, 32'h0);
        wr(mct_pkg::OFF_MODE, 32'h5C);
        repeat (36) @(posedge aclk);
        wr(mct_pkg::OFF_MODE, 32'h18);
        rd(mct_pkg::OFF_GR_BASE + 8'h04);
        `CHK("compl xfer", 32'h8, d)
        rd(mct_pkg::OFF_FLAGS);
        `CHK("compl flags", 9'h118, d[8:0])
        conclude();
    end
endmodule // tb_top
